// File: rx_entry_store.sv
`timescale 1ns/1ps
`include "uart_rx_params.svh"

// Two-entry receive store; read word always registered
module rx_entry_store
  import uart_rx_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic flush,
  input wire logic push,
  input wire rx_entry_s push_entry,
  input wire logic pop,
  output rx_entry_s head,
  output logic [1:0] count
);

  rx_entry_s mem_r [0:1];
  logic wptr_r;
  logic rptr_r;
  logic [1:0] count_r;
  logic do_push;
  logic do_pop;

  assign do_pop = pop && (count_r != 2'h0);
  assign do_push = push && ((count_r != 2'h2) || do_pop);
  assign count = count_r;

  always_ff @(posedge clk)
  begin
    if (do_push)
    begin
      mem_r[wptr_r] <= push_entry;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst || flush)
    begin
      wptr_r <= 1'b0;
      rptr_r <= 1'b0;
      count_r <= 2'h0;
    end
    else
    begin
      if (do_push)
      begin
        wptr_r <= ~wptr_r;
      end
      if (do_pop)
      begin
        rptr_r <= ~rptr_r;
      end
      count_r <= count_r + {1'b0, do_push} - {1'b0, do_pop};
    end
  end

  // Head register: next entry visible one cycle after push or pop
  logic rptr_nxt;
  assign rptr_nxt = do_pop ? ~rptr_r : rptr_r;

  always_ff @(posedge clk)
  begin
    if (!nrst || flush)
    begin
      head <= '0;
    end
    else if (do_push && ((count_r == 2'h0) || (count_r == 2'h1 && do_pop)))
    begin
      head <= push_entry;
    end
    else if (do_pop)
    begin
      head <= mem_r[rptr_nxt];
    end
  end

endmodule : rx_entry_store

// File: serial_tx_model.sv
`timescale 1ns/1ps
module serial_tx_model (
  input wire logic clk,
  input wire logic tick,
  input wire logic dbl,
  output logic line
);
  // Line idles at mark level
  initial line = 1'h1;
  task automatic hold(input logic v, input int n);
    line <= v;
    repeat (n) @(posedge clk iff tick);
  endtask : hold
  task automatic send(input logic [11:0] b, input int n);
    for (int i = 0; i < n; i++)
      hold(b[i], dbl ? 8 : 16);
    // Low stop bit: one idle bit so the next start has a falling edge
    if (!b[n - 1])
      hold(1'h1, dbl ? 8 : 16);
  endtask : send
endmodule : serial_tx_model

// File: uart_rx.sv
`timescale 1ns/1ps
`include "uart_rx_params.svh"

//
// Contract
// - Ninth bit readable, follows buffered frame
// - Ninth bit and errors stored per frame
// - Receive complete high while buffer nonempty
// - Disable flushes buffer, clears receive complete
// - Interrupt requested while flag and enables set
// - Error flags not writable by software
// - Error flags raise no interrupt
// - Frame error reflects first stop bit
// - Frame error ignores stop bit count
// - Overrun on full buffer, held frame plus start
// - Overrun cleared on successful transfer
// - Parity error zero when checking off
// - Parity computed, compared, buffered
// - Parity error only if enabled then
// - Disable abandons reception immediately
// - Each data read pops one frame
// - Sample at 16x or 8x baud
// - Idle watches falling edge, sample one
// - Start vote on samples 8-10 or 4-6
// - High majority rejects start as noise
// - Valid start resynchronises every frame
// - Sixteen or eight states per bit
// - Each bit by three-sample majority
// - Second stop bit ignored
// - Unused upper data bits read zero
//
module uart_rx
  import uart_rx_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic serial_receive_pin,
  input wire logic sample_tick,
  input wire logic receiver_enable,
  input wire logic double_speed_select,
  input wire logic [2:0] character_size_select,
  input wire logic parity_enable_bit,
  input wire logic parity_odd_select,
  input wire logic stop_bit_count_select,
  input wire logic receive_complete_irq_enable,
  input wire logic global_irq_enable,
  input wire logic data_read,
  output logic [7:0] serial_data_location,
  output logic receive_ninth_bit,
  output logic receive_complete_flag,
  output logic frame_error_flag,
  output logic overrun_flag,
  output logic parity_error_flag,
  output logic receive_irq,
  output logic pin_override
);

  // ----------------------------------------
  // Sample position decode
  // ----------------------------------------
  rx_state_e state_r;
  logic [4:0] sample_r;
  logic [3:0] bit_idx_r;
  logic [2:0] votes_r;
  logic line_prev_r;
  logic [8:0] shift_r;
  logic par_bit_r;
  logic [4:0] per_bit;
  logic [4:0] vote_first;
  logic [3:0] n_data;
  logic [3:0] last_idx;
  logic in_vote;
  logic vote_done;
  logic majority;
  logic bit_end;

  assign per_bit = double_speed_select ? `RX_SAMPLES_DOUBLE : `RX_SAMPLES_NORMAL;
  assign vote_first = double_speed_select ? `RX_VOTE_FIRST_DOUBLE : `RX_VOTE_FIRST_NORMAL;

  // Data bits: 5..8 by size code, nine for the nine-bit code
  assign n_data = (character_size_select == `RX_SIZE_NINE) ? 4'h9 :
                  (character_size_select[2] ? 4'h8 : {2'b01, character_size_select[1:0]} + 4'h1);
  // Index after data (and parity) is the first stop bit; later stops never sampled
  assign last_idx = n_data + {3'h0, parity_enable_bit};

  assign in_vote = sample_tick && (sample_r >= vote_first) && (sample_r <= vote_first + 5'h02);
  assign vote_done = sample_tick && (sample_r == vote_first + 5'h02);
  assign bit_end = sample_tick && (sample_r == per_bit);

  // Majority of the two stored samples and the current one
  always_comb
  begin
    majority = (votes_r[0] & votes_r[1]) | (votes_r[0] & serial_receive_pin) |
               (votes_r[1] & serial_receive_pin);
  end

  // ----------------------------------------
  // Receive state machine
  // ----------------------------------------
  logic stop_seen;
  logic frame_valid;
  logic start_detect;

  assign stop_seen = (state_r == st_bits) && vote_done && (bit_idx_r == last_idx);
  assign start_detect = (state_r == st_idle) && sample_tick && line_prev_r && !serial_receive_pin;

  always_ff @(posedge clk)
  begin
    if (!nrst || !receiver_enable)
    begin
      state_r <= st_idle;
      sample_r <= 5'h00;
      bit_idx_r <= 4'h0;
      line_prev_r <= `RX_LINE_IDLE;
    end
    else
    begin
      if (sample_tick)
      begin
        line_prev_r <= serial_receive_pin;
      end
      case (state_r)
        st_idle:
        begin
          if (start_detect)
          begin
            state_r <= st_start;
            sample_r <= 5'h02;
          end
        end
        st_start:
        begin
          if (sample_tick)
          begin
            sample_r <= sample_r + 5'h01;
          end
          if (vote_done)
          begin
            if (majority)
            begin
              state_r <= st_idle;
              sample_r <= 5'h00;
            end
          end
          if (bit_end)
          begin
            state_r <= st_bits;
            sample_r <= 5'h01;
            bit_idx_r <= 4'h0;
          end
        end
        st_bits:
        begin
          if (sample_tick)
          begin
            sample_r <= (sample_r == per_bit) ? 5'h01 : sample_r + 5'h01;
          end
          if (bit_end)
          begin
            bit_idx_r <= bit_idx_r + 4'h1;
          end
          if (stop_seen)
          begin
            state_r <= st_idle;
            sample_r <= 5'h00;
            // Line history stays live: a low stop bit must not fake a start edge
          end
        end
        default:
        begin
          state_r <= st_idle;
        end
      endcase
    end
  end

  // Vote sample capture
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      votes_r <= 3'h0;
    end
    else if (in_vote)
    begin
      votes_r <= {votes_r[1:0], serial_receive_pin};
    end
  end

  // ----------------------------------------
  // Bit assembly and parity
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!nrst || start_detect)
    begin
      shift_r <= `RX_DATA_RESET;
      par_bit_r <= 1'b0;
    end
    else if ((state_r == st_bits) && vote_done)
    begin
      if (bit_idx_r < n_data)
      begin
        shift_r[bit_idx_r] <= majority;
      end
      else if (parity_enable_bit && (bit_idx_r == n_data))
      begin
        par_bit_r <= majority;
      end
    end
  end

  logic parity_calc;
  logic parity_bad;

  assign parity_calc = (^shift_r) ^ parity_odd_select;
  assign parity_bad = parity_enable_bit && (parity_calc != par_bit_r);

  // ----------------------------------------
  // Shift register hold and overrun
  // ----------------------------------------
  logic waiting_r;
  logic ovr_pending_r;
  rx_entry_s wait_entry_r;
  rx_entry_s new_entry;
  logic [1:0] count;
  logic store_full;
  logic push;
  logic pop;
  rx_entry_s head;

  assign pop = data_read && (count != 2'h0);
  assign store_full = (count == 2'h2) && !pop;
  assign frame_valid = stop_seen;

  always_comb
  begin
    new_entry.data = shift_r;
    new_entry.frame_err = ~majority;
    new_entry.overrun = ovr_pending_r;
    new_entry.parity_err = parity_bad;
  end

  // Held frame waits in the shift stage while the store is full
  assign push = (frame_valid || waiting_r) && !store_full;

  always_ff @(posedge clk)
  begin
    if (!nrst || !receiver_enable)
    begin
      waiting_r <= 1'b0;
      wait_entry_r <= '0;
    end
    else if (frame_valid && (store_full || waiting_r))
    begin
      waiting_r <= 1'b1;
      wait_entry_r <= new_entry;
    end
    else if (push)
    begin
      waiting_r <= 1'b0;
    end
  end

  // Lost frame marks the next transferred entry; cleared on transfer
  always_ff @(posedge clk)
  begin
    if (!nrst || !receiver_enable)
    begin
      ovr_pending_r <= 1'b0;
    end
    else if (start_detect && waiting_r && store_full)
    begin
      ovr_pending_r <= 1'b1;
    end
    else if (push)
    begin
      ovr_pending_r <= 1'b0;
    end
  end

  rx_entry_s push_entry;
  always_comb
  begin
    push_entry = waiting_r ? wait_entry_r : new_entry;
    if (waiting_r && ovr_pending_r)
    begin
      push_entry.overrun = 1'b1;
    end
  end

  rx_entry_store store (
    .clk(clk),
    .nrst(nrst),
    .flush(!receiver_enable),
    .push(push),
    .push_entry(push_entry),
    .pop(pop),
    .head(head),
    .count(count)
  );

  // ----------------------------------------
  // Software view
  // ----------------------------------------
  // Data, ninth bit and error flags come from the head register; no write path exists
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      serial_data_location <= 8'h00;
      receive_ninth_bit <= 1'b0;
      frame_error_flag <= 1'b0;
      overrun_flag <= 1'b0;
      parity_error_flag <= 1'b0;
      receive_complete_flag <= 1'b0;
      receive_irq <= 1'b0;
      pin_override <= 1'b0;
    end
    else
    begin
      serial_data_location <= head.data[7:0];
      receive_ninth_bit <= head.data[8];
      frame_error_flag <= head.frame_err;
      overrun_flag <= head.overrun;
      parity_error_flag <= head.parity_err;
      receive_complete_flag <= receiver_enable && (count != 2'h0);
      // Error flags take no part here
      receive_irq <= receiver_enable && (count != 2'h0) && receive_complete_irq_enable &&
                     global_irq_enable;
      pin_override <= receiver_enable;
    end
  end

endmodule : uart_rx

// File: uart_rx_params.svh
`ifndef UART_RX_PARAMS_SVH
`define UART_RX_PARAMS_SVH

// ----------------------------------------
// Sampling
// ----------------------------------------
`define RX_SAMPLES_NORMAL 5'h10
`define RX_SAMPLES_DOUBLE 5'h08
`define RX_VOTE_FIRST_NORMAL 5'h08
`define RX_VOTE_FIRST_DOUBLE 5'h04

// ----------------------------------------
// Frame format
// ----------------------------------------
`define RX_SIZE_NINE 3'h7
`define RX_SIZE_FIVE 3'h0
`define RX_BUF_DEPTH 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RX_LINE_IDLE 1'b1
`define RX_DATA_RESET 9'h000

`endif

// File: uart_rx_pkg.sv
package uart_rx_pkg;

  typedef enum logic [1:0] {
    st_idle,
    st_start,
    st_bits
  } rx_state_e;

  typedef struct packed {
    logic [8:0] data;
    logic frame_err;
    logic overrun;
    logic parity_err;
  } rx_entry_s;

endpackage : uart_rx_pkg

// File: uart_rx_sva.sv
`timescale 1ns/1ps
module uart_rx_sva (
  input wire logic clk,
  input wire logic nrst,
  input wire logic receiver_enable,
  input wire logic receive_complete_irq_enable,
  input wire logic global_irq_enable,
  input wire logic data_read,
  input wire logic [7:0] serial_data_location,
  input wire logic receive_ninth_bit,
  input wire logic receive_complete_flag,
  input wire logic frame_error_flag,
  input wire logic overrun_flag,
  input wire logic parity_error_flag,
  input wire logic receive_irq,
  input wire logic pin_override
);
  logic [1:0] quiet_r;
  // ----
  // Cycles since last data read or disable, saturating at 3
  // ----
  always_ff @(posedge clk)
  begin
    if (!nrst || data_read || !receiver_enable)
      quiet_r <= 2'h0;
    else if (quiet_r != 2'h3)
      quiet_r <= quiet_r + 2'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_flag_flush: assert property ($fell(receiver_enable) |-> ##[1:3] !receive_complete_flag)
    else $error("flag kept after disable");
  a_flag_off: assert property ((!receiver_enable)[*3] |-> !receive_complete_flag)
    else $error("flag while disabled");
  a_irq_on: assert property ((receive_complete_flag && receive_complete_irq_enable && global_irq_enable)[*3] |-> receive_irq)
    else $error("irq missing");
  a_irq_err: assert property ((!receive_complete_flag)[*2] |-> !receive_irq)
    else $error("irq without flag");
  a_irq_gate: assert property ((!global_irq_enable)[*2] |-> !receive_irq)
    else $error("irq not gated");
  a_flag_hold: assert property (quiet_r == 2'h3 && $past(receive_complete_flag) |-> receive_complete_flag)
    else $error("flag dropped");
  a_head_hold: assert property (quiet_r == 2'h3 && $past(receive_complete_flag) |->
    $stable({serial_data_location, receive_ninth_bit, frame_error_flag, overrun_flag, parity_error_flag}))
    else $error("head moved");
  a_pin_free: assert property ((!receiver_enable)[*2] |-> !pin_override)
    else $error("pin held");
endmodule : uart_rx_sva

bind uart_rx uart_rx_sva u_sva (
  .clk(clk),
  .nrst(nrst),
  .receiver_enable(receiver_enable),
  .receive_complete_irq_enable(receive_complete_irq_enable),
  .global_irq_enable(global_irq_enable),
  .data_read(data_read),
  .serial_data_location(serial_data_location),
  .receive_ninth_bit(receive_ninth_bit),
  .receive_complete_flag(receive_complete_flag),
  .frame_error_flag(frame_error_flag),
  .overrun_flag(overrun_flag),
  .parity_error_flag(parity_error_flag),
  .receive_irq(receive_irq),
  .pin_override(pin_override)
);

// File: uart_rx_tb.sv
`timescale 1ns/1ps
module uart_rx_tb;
  logic clk = 1'h0, nrst = 1'h0, tick = 1'h0, en = 1'h0, dbl = 1'h0, par_en = 1'h0, par_odd = 1'h0;
  logic sbs = 1'h0, ie = 1'h1, gie = 1'h1, rd = 1'h0, line, nine, flag, fe, ov, perr, irq, pin_ov;
  logic [2:0] csz = 3'h3;
  logic [7:0] dout;
  int miscompares = 0, compares = 0, tc = 0;
  serial_tx_model u_tx (.clk(clk), .tick(tick), .dbl(dbl), .line(line));
  uart_rx u_dut (.clk(clk), .nrst(nrst), .serial_receive_pin(line), .sample_tick(tick),
    .receiver_enable(en), .double_speed_select(dbl), .character_size_select(csz),
    .parity_enable_bit(par_en), .parity_odd_select(par_odd), .stop_bit_count_select(sbs),
    .receive_complete_irq_enable(ie), .global_irq_enable(gie), .data_read(rd),
    .serial_data_location(dout), .receive_ninth_bit(nine), .receive_complete_flag(flag),
    .frame_error_flag(fe), .overrun_flag(ov), .parity_error_flag(perr), .receive_irq(irq),
    .pin_override(pin_ov));
  initial
  begin
    forever #50 clk = ~clk;
  end
  // Sample tick every second clock keeps frames short
  always @(posedge clk)
  begin
    tc <= tc + 1;
    tick <= tc[0];
  end
  task automatic end_of_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'h1)
    begin
      miscompares++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic clks(input int n);
    repeat (n) @(negedge clk);
  endtask : clks
  task automatic tx(input logic [8:0] d, input int nb, input logic bad, input logic stp);
    logic [11:0] v;
    logic p;
    int n;
    v = 12'h000;
    p = par_odd ^ bad;
    for (n = 0; n < nb; n++)
    begin
      v[n + 1] = d[n];
      p ^= d[n];
    end
    n = nb + 1;
    if (par_en)
    begin
      v[n] = p;
      n++;
    end
    v[n] = stp;
    u_tx.send(v, n + 1);
  endtask : tx
  // Expected {ninth, data} and {frame, overrun, parity}, then pop
  task automatic rx(input logic [8:0] d, input logic [2:0] e);
    int i;
    clks(1);
    for (i = 0; i < 4000 && flag !== 1'h1; i++)
      clks(1);
    if (i == 4000)
    begin
      miscompares++;
      end_of_test();
    end
    chk({nine, dout, fe, ov, perr} === {d, e}, "frame content");
    @(posedge clk) rd <= 1'h1;
    @(posedge clk) rd <= 1'h0;
    clks(3);
  endtask : rx
  task automatic t_basic;
    tx(9'h0A5, 8, 1'h0, 1'h1);
    tx(9'h03C, 8, 1'h0, 1'h1);
    clks(4);
    chk(irq === 1'h1, "irq");
    chk(pin_ov === 1'h1, "pin not taken");
    @(posedge clk) gie <= 1'h0;
    clks(3);
    chk(irq === 1'h0, "irq gate");
    @(posedge clk) gie <= 1'h1;
    ie <= 1'h0;
    clks(3);
    chk(irq === 1'h0, "irq enable");
    @(posedge clk) ie <= 1'h1;
    rx(9'h0A5, 3'h0);
    rx(9'h03C, 3'h0);
    chk(flag === 1'h0 && irq === 1'h0, "not empty");
    $display("end basic");
  endtask : t_basic
  task automatic t_size;
    @(posedge clk) csz <= 3'h7;
    tx(9'h1C3, 9, 1'h0, 1'h1);
    tx(9'h03C, 9, 1'h0, 1'h1);
    rx(9'h1C3, 3'h0);
    rx(9'h03C, 3'h0);
    @(posedge clk) csz <= 3'h0;
    tx(9'h0F5, 5, 1'h0, 1'h1);
    rx(9'h015, 3'h0);
    @(posedge clk) csz <= 3'h3;
    $display("end size");
  endtask : t_size
  task automatic t_par;
    @(posedge clk) par_en <= 1'h1;
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk) par_odd <= k[1];
      clks(1);
      tx(9'h055, 8, k[0], 1'h1);
      rx(9'h055, {2'h0, k[0]});
    end
    tx(9'h055, 8, 1'h1, 1'h1);
    @(posedge clk) par_en <= 1'h0;
    rx(9'h055, 3'h1);
    $display("end parity");
  endtask : t_par
  task automatic t_fe;
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk) sbs <= k[0];
      tx(9'h0F0, 8, 1'h0, 1'h0);
      rx(9'h0F0, 3'h4);
    end
    $display("end frame error");
  endtask : t_fe
  task automatic t_ovr;
    for (int k = 1; k < 5; k++)
      tx(k[8:0], 8, 1'h0, 1'h1);
    rx(9'h001, 3'h0);
    rx(9'h002, 3'h0);
    // Third frame is lost in the shift stage; the fourth carries the overrun mark
    rx(9'h004, 3'h2);
    tx(9'h006, 8, 1'h0, 1'h1);
    clks(1);
    chk(flag === 1'h1, "flag before flush");
    @(posedge clk) en <= 1'h0;
    clks(3);
    chk(flag === 1'h0 && pin_ov === 1'h0, "not flushed");
    @(posedge clk) en <= 1'h1;
    tx(9'h005, 8, 1'h0, 1'h1);
    rx(9'h005, 3'h0);
    $display("end overrun");
  endtask : t_ovr
  task automatic t_dis;
    fork
      tx(9'h0C3, 8, 1'h0, 1'h1);
      begin
        clks(120);
        @(posedge clk) en <= 1'h0;
      end
    join
    @(posedge clk) en <= 1'h1;
    tx(9'h05A, 8, 1'h0, 1'h1);
    rx(9'h05A, 3'h0);
    chk(flag === 1'h0, "aborted frame kept");
    $display("end disable");
  endtask : t_dis
  task automatic t_spike;
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk) dbl <= k[0];
      u_tx.hold(1'h0, k ? 3 : 7);
      u_tx.hold(1'h1, 16);
      tx(9'h096, 8, 1'h0, 1'h1);
      rx(9'h096, 3'h0);
      chk(flag === 1'h0, "spike taken");
    end
    @(posedge clk) dbl <= 1'h0;
    $display("end spike");
  endtask : t_spike
  initial
  begin
    repeat (8) @(posedge clk);
    nrst <= 1'h1;
    en <= 1'h1;
    clks(2);
    t_basic();
    t_size();
    t_par();
    t_fe();
    t_ovr();
    t_dis();
    t_spike();
    end_of_test();
  end
endmodule : uart_rx_tb
